/* File: design/lbl_pkg.sv */
// constants, timing figures and state codes for the link bootstrap loader
package lbl_pkg;

   // ----------------------------------------------------------------
   // clock and link timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int LINK_BIT_NS_STD = 100;   // 10 Mbit/s, twice the reference clock
   localparam int LINK_BIT_NS_FAST = 50;   // 20 Mbit/s
   // bit periods round down to whole cycles (12 and 6)
   localparam logic [7:0] BIT_CYC_STD = 8'(CLK_MHZ * LINK_BIT_NS_STD / 1000);
   localparam logic [7:0] BIT_CYC_FAST = 8'(CLK_MHZ * LINK_BIT_NS_FAST / 1000);
   localparam logic [1:0] SETTLE_DONE = 2'h3;

   // ----------------------------------------------------------------
   // link framing
   // ----------------------------------------------------------------
   localparam int LINK_COUNT = 2;
   localparam logic [3:0] RX_PHASE_TYPE = 4'h1;
   localparam logic [3:0] RX_PHASE_STOP = 4'ha;
   localparam logic [3:0] TX_DATA_REST = 4'ha;   // bits after the start bit
   localparam logic [3:0] TX_ACK_REST = 4'h1;

   // ----------------------------------------------------------------
   // memory map and control bytes
   // ----------------------------------------------------------------
   localparam logic [15:0] ROM_BOOT_VECTOR = 16'h7ffe;
   localparam logic [15:0] FIRST_FREE_ADDRESS = 16'h8024;
   localparam logic [7:0] CTRL_POKE = 8'h00;
   localparam logic [7:0] CTRL_PEEK = 8'h01;
   localparam int FIFO_DEPTH = 32;
   localparam int BYTE_W = 8;

   typedef enum logic [11:0] {
      ST_WAIT = 12'h001,
      ST_CTRL = 12'h002,
      ST_LOAD = 12'h004,
      ST_GO = 12'h008,
      ST_ADDR_LO = 12'h010,
      ST_ADDR_HI = 12'h020,
      ST_DATA_LO = 12'h040,
      ST_DATA_HI = 12'h080,
      ST_PEEK_RD = 12'h100,
      ST_PEEK_CAP = 12'h200,
      ST_PEEK_TX = 12'h400,
      ST_RUN = 12'h800
   } lbl_state_type;

endpackage : lbl_pkg

/* File: design/lbl_stream_if.sv */
// valid/ready byte stream between loader modules
`timescale 1ns/1ps
interface lbl_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : lbl_stream_if

/* File: design/lbl_fifo.sv */
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module lbl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic reset,
   lbl_stream_if.snk wr,
   lbl_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic full;
   logic empty;

   assign empty = (wp_r == rp_r);
   assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data = mem_r[rp_r[AW-1:0]];

   always_ff @(posedge clk) begin
      if (reset) begin
         wp_r <= '0;
      end else if (wr.valid && !full) begin
         wp_r <= wp_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rp_r <= '0;
      end else if (rd.ready && !empty) begin
         rp_r <= rp_r + 1'b1;
      end
   end

   // storage carries no reset; empty pointers hide stale words
   always_ff @(posedge clk) begin
      if (wr.valid && !full) begin
         mem_r[wp_r[AW-1:0]] <= wr.data;
      end
   end

endmodule : lbl_fifo

/* File: design/lbl_link.sv */
// one serial link: input channel with deferred acknowledge, output channel
`timescale 1ns/1ps
module lbl_link import lbl_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic rate_fast,
   input wire logic link_in,
   output logic link_out,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   logic in_meta_r;
   logic in_sync_r;
   logic [7:0] bit_cyc;
   logic rx_busy_r;
   logic [7:0] rx_cnt_r;
   logic [3:0] rx_phase_r;
   logic [7:0] rx_shift_r;
   logic rx_full_r;
   logic ack_rx_r;
   logic ack_owed_r;
   logic tx_busy_r;
   logic [7:0] tx_cnt_r;
   logic [3:0] tx_left_r;
   logic [9:0] tx_shift_r;
   logic tx_wait_ack_r;
   logic link_out_r;
   logic rx_take;

   assign bit_cyc = rate_fast ? BIT_CYC_FAST : BIT_CYC_STD;
   assign rx_data = rx_shift_r;
   assign rx_valid = rx_full_r;
   assign rx_take = rx_full_r && rx_ready;
   assign link_out = link_out_r;
   assign tx_ready = !tx_busy_r && !tx_wait_ack_r && !ack_owed_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         in_meta_r <= 1'b0;
         in_sync_r <= 1'b0;
      end else begin
         in_meta_r <= link_in;
         in_sync_r <= in_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // receiver: samples at bit centres; a low idle line never starts
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_busy_r <= 1'b0;
         rx_cnt_r <= 8'h00;
         rx_phase_r <= 4'h0;
         rx_shift_r <= 8'h00;
         ack_rx_r <= 1'b0;
      end else begin
         ack_rx_r <= 1'b0;
         if (!rx_busy_r) begin
            if (in_sync_r && !rx_full_r) begin
               rx_busy_r <= 1'b1;
               rx_cnt_r <= {1'b0, bit_cyc[7:1]};
               rx_phase_r <= 4'h0;
            end
         end else if (rx_cnt_r != 8'h00) begin
            rx_cnt_r <= rx_cnt_r - 8'h01;
         end else begin
            rx_cnt_r <= bit_cyc - 8'h01;
            rx_phase_r <= rx_phase_r + 4'h1;
            if (rx_phase_r == RX_PHASE_TYPE && !in_sync_r) begin
               ack_rx_r <= 1'b1;
               rx_busy_r <= 1'b0;
            end else if (rx_phase_r == RX_PHASE_STOP) begin
               rx_busy_r <= 1'b0;
            end else if (rx_phase_r > RX_PHASE_TYPE) begin
               rx_shift_r <= {in_sync_r, rx_shift_r[7:1]};
            end
         end
      end
   end

   // byte held until taken; the sender waits for our acknowledge meanwhile
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_full_r <= 1'b0;
      end else if (rx_busy_r && rx_cnt_r == 8'h00 && rx_phase_r == RX_PHASE_STOP) begin
         rx_full_r <= 1'b1;
      end else if (rx_take) begin
         rx_full_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // transmitter: acknowledges go first, data waits for its acknowledge
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_busy_r <= 1'b0;
         tx_cnt_r <= 8'h00;
         tx_left_r <= 4'h0;
         tx_shift_r <= 10'h000;
         link_out_r <= 1'b0;
         ack_owed_r <= 1'b0;
      end else begin
         if (!tx_busy_r) begin
            if (ack_owed_r) begin
               tx_busy_r <= 1'b1;
               link_out_r <= 1'b1;
               tx_shift_r <= 10'h000;
               tx_left_r <= TX_ACK_REST;
               tx_cnt_r <= bit_cyc - 8'h01;
               ack_owed_r <= 1'b0;
            end else if (tx_valid && !tx_wait_ack_r) begin
               tx_busy_r <= 1'b1;
               link_out_r <= 1'b1;
               tx_shift_r <= {1'b0, tx_data, 1'b1};
               tx_left_r <= TX_DATA_REST;
               tx_cnt_r <= bit_cyc - 8'h01;
            end
         end else if (tx_cnt_r != 8'h00) begin
            tx_cnt_r <= tx_cnt_r - 8'h01;
         end else if (tx_left_r != 4'h0) begin
            link_out_r <= tx_shift_r[0];
            tx_shift_r <= {1'b0, tx_shift_r[9:1]};
            tx_left_r <= tx_left_r - 4'h1;
            tx_cnt_r <= bit_cyc - 8'h01;
         end else begin
            tx_busy_r <= 1'b0;
            link_out_r <= 1'b0;
         end
         if (rx_take) begin
            ack_owed_r <= 1'b1;
         end
      end
   end

   // armed with the start bit, so an early acknowledge is never missed
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_wait_ack_r <= 1'b0;
      end else if (!tx_busy_r && !ack_owed_r && tx_valid && !tx_wait_ack_r) begin
         tx_wait_ack_r <= 1'b1;
      end else if (ack_rx_r) begin
         tx_wait_ack_r <= 1'b0;
      end
   end

endmodule : lbl_link

/* File: design/lbl_loader.sv */
// start-up loader: rom boot or link boot with load, poke and peek
`timescale 1ns/1ps
//
// Summary of operation
// - boot source select high boots from rom, low boots from a link.
// - rom boot starts a low-priority process at the top two bytes.
// - rom boot places the workspace at the first free address.
// - internal rom disable high fetches the rom vector from external memory.
// - link boot waits for a control byte on either link, first wins.
// - control byte two or more counts bytes stored from first free address.
// - loaded code runs from first free address, workspace just above it.
// - control byte zero: address then word written, then wait again.
// - control byte one: address, word read and sent back on same link.
// - two links, each with one input and one output channel.
// - acknowledge is sent only after a whole data byte has arrived.
// - acknowledge accepted any time after the data start bit went out.
// - link rate is twice reference clock, doubled when rate select high.
// - reset drives link outputs low; inputs held low meanwhile.
// - reset falling with analyse low boots; reset loses all state.
// - analyse falling after reset boots again, keeping state peekable.
//
module lbl_loader import lbl_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic boot_source_select,
   input wire logic internal_rom_disable,
   input wire logic link_rate_select,
   input wire logic analyse,
   input wire logic [LINK_COUNT-1:0] serial_link_input,
   output logic [LINK_COUNT-1:0] serial_link_output,
   input wire logic [7:0] mem_rdata,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_write,
   output logic mem_read,
   output logic proc_start,
   output logic [15:0] proc_iptr,
   output logic [15:0] proc_wptr,
   output logic boot_vector_external,
   output logic analysis_boot
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   // pin bits: 0 boot source, 1 rom disable, 2 rate, 3 analyse
   logic [3:0] pin_meta_r;
   logic [3:0] pin_sync_r;
   logic [1:0] settle_r;
   lbl_state_type state_r;
   logic rom_boot_r;
   logic [7:0] count_r;
   logic [15:0] ptr_r;
   logic [15:0] addr_r;
   logic peek_r;
   logic hi_byte_r;
   logic locked_r;
   logic sel_r;
   logic sel_cur;
   logic link_phase;
   logic fire;
   logic tx_done;
   logic end_txn;
   logic [LINK_COUNT-1:0] rx_valid;
   logic [LINK_COUNT-1:0] rx_ready;
   logic [LINK_COUNT-1:0] tx_ready;
   logic [LINK_COUNT-1:0] tx_valid_r;
   logic [7:0] tx_data_r;
   logic [7:0] rx_data [LINK_COUNT];
   logic [15:0] mem_addr_r;
   logic [7:0] mem_wdata_r;
   logic mem_write_r;
   logic mem_read_r;
   logic proc_start_r;
   logic [15:0] proc_iptr_r;
   logic [15:0] proc_wptr_r;
   logic boot_vector_external_r;
   logic analysis_boot_r;

   lbl_stream_if #(.WIDTH(BYTE_W)) fin ();
   lbl_stream_if #(.WIDTH(BYTE_W)) fout ();

   assign mem_addr = mem_addr_r;
   assign mem_wdata = mem_wdata_r;
   assign mem_write = mem_write_r;
   assign mem_read = mem_read_r;
   assign proc_start = proc_start_r;
   assign proc_iptr = proc_iptr_r;
   assign proc_wptr = proc_wptr_r;
   assign boot_vector_external = boot_vector_external_r;
   assign analysis_boot = analysis_boot_r;

   // ----------------------------------------------------------------
   // pin synchronisers and settling after reset
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_meta_r <= 4'h0;
         pin_sync_r <= 4'h0;
      end else begin
         pin_meta_r <= {analyse, link_rate_select, internal_rom_disable, boot_source_select};
         pin_sync_r <= pin_meta_r;
      end
   end

   // straps are only trusted once the synchronisers hold real pin levels
   always_ff @(posedge clk) begin
      if (reset) begin
         settle_r <= 2'h0;
      end else if (settle_r != SETTLE_DONE) begin
         settle_r <= settle_r + 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // links and input buffer
   // ----------------------------------------------------------------
   genvar g;
   for (g = 0; g < LINK_COUNT; g++) begin : g_link
      lbl_link u_link (
         .clk(clk),
         .reset(reset),
         .rate_fast(pin_sync_r[2]),
         .link_in(serial_link_input[g]),
         .link_out(serial_link_output[g]),
         .rx_data(rx_data[g]),
         .rx_valid(rx_valid[g]),
         .rx_ready(rx_ready[g]),
         .tx_data(tx_data_r),
         .tx_valid(tx_valid_r[g]),
         .tx_ready(tx_ready[g])
      );
   end

   lbl_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset(reset),
      .wr(fin),
      .rd(fout)
   );

   // unlocked, link 0 wins a tie; the losing link is stalled, not dropped
   always_comb begin
      link_phase = !(state_r inside {ST_WAIT, ST_GO, ST_RUN});
      sel_cur = locked_r ? sel_r : !rx_valid[0];
      fin.valid = link_phase && rx_valid[sel_cur];
      fin.data = rx_data[sel_cur];
      rx_ready[0] = link_phase && fin.ready && !sel_cur;
      rx_ready[1] = link_phase && fin.ready && sel_cur;
      fout.ready = state_r inside {ST_CTRL, ST_LOAD, ST_ADDR_LO, ST_ADDR_HI,
                                   ST_DATA_LO, ST_DATA_HI};
      fire = fout.valid && fout.ready;
      tx_done = tx_valid_r[sel_r] && tx_ready[sel_r];
      end_txn = (state_r == ST_DATA_HI && fire) || (state_r == ST_PEEK_TX && tx_done
                && hi_byte_r);
   end

   // a new byte keeps the lock even when a transaction ends alongside it
   always_ff @(posedge clk) begin
      if (reset) begin
         locked_r <= 1'b0;
         sel_r <= 1'b0;
      end else if (fin.valid && fin.ready) begin
         locked_r <= 1'b1;
         sel_r <= sel_cur;
      end else if (end_txn) begin
         locked_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= ST_WAIT;
         rom_boot_r <= 1'b0;
         count_r <= 8'h00;
         ptr_r <= FIRST_FREE_ADDRESS;
         addr_r <= 16'h0000;
         peek_r <= 1'b0;
         hi_byte_r <= 1'b0;
      end else begin
         case (state_r)
            ST_WAIT: begin
               if (settle_r == SETTLE_DONE && !pin_sync_r[3]) begin
                  rom_boot_r <= pin_sync_r[0];
                  state_r <= pin_sync_r[0] ? ST_GO : ST_CTRL;
               end
            end
            ST_CTRL: begin
               if (fire) begin
                  if (fout.data > CTRL_PEEK) begin
                     count_r <= fout.data;
                     ptr_r <= FIRST_FREE_ADDRESS;
                     state_r <= ST_LOAD;
                  end else begin
                     peek_r <= (fout.data == CTRL_PEEK);
                     state_r <= ST_ADDR_LO;
                  end
               end
            end
            ST_LOAD: begin
               if (fire) begin
                  ptr_r <= ptr_r + 16'h0001;
                  count_r <= count_r - 8'h01;
                  if (count_r == 8'h01) begin
                     state_r <= ST_GO;
                  end
               end
            end
            ST_ADDR_LO: begin
               if (fire) begin
                  addr_r[7:0] <= fout.data;
                  state_r <= ST_ADDR_HI;
               end
            end
            ST_ADDR_HI: begin
               if (fire) begin
                  addr_r[15:8] <= fout.data;
                  hi_byte_r <= 1'b0;
                  state_r <= peek_r ? ST_PEEK_RD : ST_DATA_LO;
               end
            end
            ST_DATA_LO: begin
               if (fire) begin
                  addr_r <= addr_r + 16'h0001;
                  state_r <= ST_DATA_HI;
               end
            end
            ST_DATA_HI: begin
               if (fire) begin
                  state_r <= ST_CTRL;
               end
            end
            ST_PEEK_RD: state_r <= ST_PEEK_CAP;
            ST_PEEK_CAP: state_r <= ST_PEEK_TX;
            ST_PEEK_TX: begin
               if (tx_done) begin
                  addr_r <= addr_r + 16'h0001;
                  hi_byte_r <= 1'b1;
                  state_r <= hi_byte_r ? ST_CTRL : ST_PEEK_RD;
               end
            end
            ST_GO: state_r <= ST_RUN;
            ST_RUN: state_r <= ST_RUN;
            default: state_r <= ST_WAIT;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // memory port: one byte per access, read data sampled in the cycle the strobe stands
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         mem_addr_r <= 16'h0000;
         mem_wdata_r <= 8'h00;
         mem_write_r <= 1'b0;
         mem_read_r <= 1'b0;
      end else begin
         mem_write_r <= fire && (state_r inside {ST_LOAD, ST_DATA_LO, ST_DATA_HI});
         mem_read_r <= (state_r == ST_PEEK_RD);
         mem_wdata_r <= fout.data;
         mem_addr_r <= (state_r == ST_LOAD) ? ptr_r : addr_r;
      end
   end

   // peek reply leaves on the output paired with the input it came in on
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_valid_r <= '0;
         tx_data_r <= 8'h00;
      end else if (state_r == ST_PEEK_CAP) begin
         tx_data_r <= mem_rdata;
         tx_valid_r[sel_r] <= 1'b1;
      end else begin
         tx_valid_r <= tx_valid_r & ~tx_ready;
      end
   end

   // ----------------------------------------------------------------
   // process start
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         proc_start_r <= 1'b0;
         proc_iptr_r <= 16'h0000;
         proc_wptr_r <= 16'h0000;
         boot_vector_external_r <= 1'b0;
         analysis_boot_r <= 1'b0;
      end else begin
         proc_start_r <= (state_r == ST_GO);
         if (state_r == ST_WAIT && settle_r == SETTLE_DONE && pin_sync_r[3]) begin
            analysis_boot_r <= 1'b1;
         end
         if (state_r == ST_GO) begin
            if (rom_boot_r) begin
               proc_iptr_r <= ROM_BOOT_VECTOR;
               proc_wptr_r <= FIRST_FREE_ADDRESS;
               boot_vector_external_r <= pin_sync_r[1];
            end else begin
               proc_iptr_r <= FIRST_FREE_ADDRESS;
               proc_wptr_r <= ptr_r;
               boot_vector_external_r <= 1'b0;
            end
         end
      end
   end

endmodule : lbl_loader

/* File: tb/lbl_loader_assertions.sv */
// port-level checks for the link bootstrap loader
`timescale 1ns/1ps
module lbl_loader_assertions import lbl_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic boot_source_select,
   input wire logic internal_rom_disable,
   input wire logic link_rate_select,
   input wire logic analyse,
   input wire logic [LINK_COUNT-1:0] serial_link_input,
   input wire logic [LINK_COUNT-1:0] serial_link_output,
   input wire logic [7:0] mem_rdata,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_write,
   input wire logic mem_read,
   input wire logic proc_start,
   input wire logic [15:0] proc_iptr,
   input wire logic [15:0] proc_wptr,
   input wire logic boot_vector_external,
   input wire logic analysis_boot
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // ------
   // properties
   // ------
   property p_reset_quiet;
      $fell(reset) |-> serial_link_output == 2'h0 && !proc_start && !mem_write;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
   property p_start_once;
      proc_start |=> !proc_start [*8];
   endproperty
   a_start_once: assert property (p_start_once) else $error("second start pulse");
   property p_rom_vec;
      proc_start && boot_source_select |-> proc_iptr == 16'h7ffe && proc_wptr == 16'h8024;
   endproperty
   a_rom_vec: assert property (p_rom_vec) else $error("rom boot pointers wrong");
   property p_rom_src;
      proc_start && boot_source_select |-> boot_vector_external == internal_rom_disable;
   endproperty
   a_rom_src: assert property (p_rom_src) else $error("rom vector source wrong");
   property p_link_vec;
      proc_start && !boot_source_select |-> proc_iptr == 16'h8024 && proc_wptr >= 16'h8026;
   endproperty
   a_link_vec: assert property (p_link_vec) else $error("link boot pointers wrong");
   property p_load_then_go;
      proc_start && !boot_source_select |-> $past(mem_write) && $past(mem_addr) + 16'h1 == proc_wptr;
   endproperty
   a_load_then_go: assert property (p_load_then_go) else $error("start not after load");
   property p_analyse_hold;
      analyse [*5] |-> !proc_start;
   endproperty
   a_analyse_hold: assert property (p_analyse_hold) else $error("start while held");
   property p_peek_reply;
      mem_read |-> ##[1:200] $rose(|serial_link_output);
   endproperty
   a_peek_reply: assert property (p_peek_reply) else $error("no reply after read");
   c_rom: cover property (proc_start && boot_source_select);
   c_link: cover property (proc_start && !boot_source_select);
   c_peek: cover property (mem_read);
endmodule : lbl_loader_assertions

/* File: tb/lbl_host_model.sv */
// serial link partner: sends data packets, acknowledges received bytes
`timescale 1ns/1ps
module lbl_host_model import lbl_pkg::*; (
   input wire logic clk,
   input wire logic rate_fast,
   input wire logic link_out,
   output logic link_in
);
   logic busy = 1'b0;
   int ack_due = 0;
   int acks = 0;
   logic [7:0] sh;
   logic [7:0] rx_q[$];
   initial link_in = 1'b0; // line held low outside frames
   function automatic int per();
      return rate_fast ? int'(BIT_CYC_FAST) : int'(BIT_CYC_STD);
   endfunction : per
   task automatic put_bit(input logic b);
      link_in <= b;
      repeat (per()) @(posedge clk);
   endtask : put_bit
   // next byte only after the previous one was acknowledged or 600 cycles passed without it
   task automatic send_byte(input logic [7:0] b);
      int a0;
      wait (!busy);
      busy = 1'b1;
      a0 = acks;
      @(posedge clk);
      put_bit(1'b1);
      put_bit(1'b1);
      for (int i = 0; i < 8; i++) put_bit(b[i]);
      put_bit(1'b0);
      busy = 1'b0;
      for (int i = 0; i < 600 && acks == a0; i++) @(posedge clk);
   endtask : send_byte
   always begin
      @(posedge link_out);
      repeat (per() / 2 + per()) @(posedge clk);
      if (link_out) begin
         for (int i = 0; i < 8; i++) begin
            repeat (per()) @(posedge clk);
            sh[i] = link_out;
         end
         repeat (per()) @(posedge clk);
         rx_q.push_back(sh);
         ack_due++;
      end else acks++;
   end
   always @(posedge clk) if (ack_due > 0 && !busy) begin
      busy = 1'b1;
      ack_due--;
      put_bit(1'b1);
      put_bit(1'b0);
      busy = 1'b0;
   end
endmodule : lbl_host_model

/* File: tb/tb.sv */
// self-checking bench for the link bootstrap loader
`timescale 1ns/1ps
module tb import lbl_pkg::*; ();
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic boot_source_select = 1'b0;
   logic internal_rom_disable = 1'b0;
   logic link_rate_select = 1'b0;
   logic analyse = 1'b0;
   wire [1:0] serial_link_input;
   logic [1:0] serial_link_output;
   logic [15:0] mem_addr, proc_iptr, proc_wptr, iptr_l, wptr_l;
   logic [7:0] mem_wdata;
   logic mem_write, mem_read, proc_start, boot_vector_external, analysis_boot;
   logic [7:0] mem [0:65535];
   wire [7:0] mem_rdata = mem_read ? mem[mem_addr] : 8'h00;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   int starts = 0;
   always #4 clk = ~clk;
   lbl_loader dut_u (.clk, .reset, .boot_source_select, .internal_rom_disable,
      .link_rate_select, .analyse, .serial_link_input, .serial_link_output, .mem_rdata,
      .mem_addr, .mem_wdata, .mem_write, .mem_read, .proc_start, .proc_iptr, .proc_wptr,
      .boot_vector_external, .analysis_boot);
   lbl_host_model host0_u (.clk(clk), .rate_fast(link_rate_select),
      .link_out(serial_link_output[0]), .link_in(serial_link_input[0]));
   lbl_host_model host1_u (.clk(clk), .rate_fast(link_rate_select),
      .link_out(serial_link_output[1]), .link_in(serial_link_input[1]));
   // memory answers while the read strobe stands; starts latched
   always @(posedge clk) begin
      if (mem_write) mem[mem_addr] <= mem_wdata;
      if (proc_start === 1'b1) begin
         starts <= starts + 1;
         iptr_l <= proc_iptr;
         wptr_l <= proc_wptr;
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic do_reset(input logic rom, input logic ext, input logic an);
      @(posedge clk);
      reset <= 1'b1;
      boot_source_select <= rom;
      internal_rom_disable <= ext;
      analyse <= an;
      repeat (2) @(posedge clk);
      check("links in reset", 16'h0, {14'h0, serial_link_output});
      reset <= 1'b0;
   endtask : do_reset
   task automatic await_start(input int s0);
      for (int n = 0; n < 500 && starts == s0; n++) @(negedge clk);
      check("start count", 16'h1, 16'(starts - s0));
   endtask : await_start
   task automatic t_rom;
      for (int e = 0; e < 2; e++) begin
         do_reset(1'b1, e[0], 1'b0);
         await_start(starts);
         check("rom iptr", 16'h7ffe, iptr_l);
         check("rom wptr", 16'h8024, wptr_l);
         check("vector ext", {15'h0, e[0]}, {15'h0, boot_vector_external});
      end
   endtask : t_rom
   task automatic t_analyse;
      int s0;
      do_reset(1'b1, 1'b0, 1'b1);
      s0 = starts;
      repeat (50) @(negedge clk);
      check("held starts", 16'h0, 16'(starts - s0));
      check("analysis flag", 16'h1, {15'h0, analysis_boot});
      @(posedge clk);
      analyse <= 1'b0;
      await_start(s0);
   endtask : t_analyse
   task automatic t_poke;
      logic [7:0] pk [5] = '{8'h00, 8'h00, 8'h81, 8'hef, 8'hbe};
      do_reset(1'b0, 1'b0, 1'b0);
      foreach (pk[i]) host1_u.send_byte(pk[i]);
      repeat (20) @(negedge clk);
      check("poke lo", 16'h00ef, {8'h0, mem[16'h8100]});
      check("poke hi", 16'h00be, {8'h0, mem[16'h8101]});
   endtask : t_poke
   task automatic t_peek;
      @(posedge clk);
      link_rate_select <= 1'b1;
      repeat (4) @(posedge clk);
      host0_u.send_byte(8'h01);
      host0_u.send_byte(8'h00);
      host0_u.send_byte(8'h81);
      for (int n = 0; n < 3000 && host0_u.rx_q.size() < 2; n++) @(negedge clk);
      check("peek count", 16'h2, 16'(host0_u.rx_q.size()));
      check("peek lo", 16'h00ef, {8'h0, host0_u.rx_q[0]});
      check("peek hi", 16'h00be, {8'h0, host0_u.rx_q[1]});
      check("other link", 16'h0, 16'(host1_u.rx_q.size()));
      repeat (40) @(posedge clk);
      link_rate_select <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : t_peek
   task automatic t_boot;
      int s0;
      s0 = starts;
      host0_u.send_byte(8'd34); // peeks and pokes all done first
      for (int i = 0; i < 34; i++) host0_u.send_byte(8'h40 + 8'(i));
      await_start(s0);
      check("load iptr", 16'h8024, iptr_l);
      check("load wptr", 16'h8046, wptr_l);
      for (int i = 0; i < 34; i++) check("code", 16'h40 + 16'(i), {8'h0, mem[16'h8024 + i]});
   endtask : t_boot
   task automatic report_and_stop;
      if (miscompares == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_rom();
      t_analyse();
      t_poke();
      t_peek();
      t_boot();
      report_and_stop();
   end
endmodule : tb
bind lbl_loader lbl_loader_assertions chk_u (.clk, .reset, .boot_source_select,
   .internal_rom_disable, .link_rate_select, .analyse, .serial_link_input, .serial_link_output,
   .mem_rdata, .mem_addr, .mem_wdata, .mem_write, .mem_read, .proc_start, .proc_iptr,
   .proc_wptr, .boot_vector_external, .analysis_boot);
